// ===== logic/dws_dual_wiper_slave.sv
`timescale 1ns/10ps
`default_nettype none
module dws_dual_wiper_slave #(
   parameter logic [3:0] DEVICE_TYPE = dws_pkg::DEV_TYPE_DEFAULT
) (
   input  wire logic                      CLOCK_I,
   input  wire logic                      RESETN_I,
   input  wire logic                      SCL_I,
   input  wire logic                      SDA_I,
   output var  logic                      SDA_O,
   output var  logic                      SDA_OE_O,
   input  wire logic [3:0]                ADDR_STRAP_I,
   output var  logic [dws_pkg::WIPER_W-1:0] WIPER_POS0_O,
   output var  logic [dws_pkg::WIPER_W-1:0] WIPER_POS1_O,
   output var  logic [dws_pkg::NUM_TAPS-1:0] TAP_SEL0_O,
   output var  logic [dws_pkg::NUM_TAPS-1:0] TAP_SEL1_O
);
   import dws_pkg::*;

   logic [1:0]        scl_sync;
   logic [1:0]        sda_sync;
   logic [3:0]        strap_meta;
   logic [3:0]        strap;
   logic              scl_last;
   logic              sda_last;
   dws_bus_evt_t      evt;

   dws_state_t        state;
   dws_state_t        pend_state;
   logic [3:0]        bit_cnt;
   logic              ack_phase;
   logic              master_ack;
   logic [7:0]        shreg;
   logic [7:0]        rd_byte;
   logic              pot_sel;
   logic [7:0]        wiper [2];
   logic              wr_strobe;
   logic              step_strobe;
   logic              step_up;
   dws_instr_t        instr;
   logic              byte_end;
   logic              ack_end;

   // address byte hit: type nibble and strapped nibble must both match
   function automatic logic addr_hit(input logic [7:0] b, input logic [3:0] s);
      return (b[7:4] == DEVICE_TYPE) && (b[3:0] == s);
   endfunction : addr_hit

   // two-stage synchronisers; only stage 1 reads stage 0
   // the strap pins share them; they are static in use, so no handshake
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         scl_sync   <= 2'h3;
         sda_sync   <= 2'h3;
         strap_meta <= 4'h0;
         strap      <= 4'h0;
      end else begin
         scl_sync   <= {scl_sync[0], SCL_I};
         sda_sync   <= {sda_sync[0], SDA_I};
         strap_meta <= ADDR_STRAP_I;
         strap      <= strap_meta;
      end
   end

   // delayed copies for edge finding, idle bus reads high
   // idle-high reset values keep a false start or stop away after reset
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         scl_last <= 1'b1;
         sda_last <= 1'b1;
      end else begin
         scl_last <= scl_sync[1];
         sda_last <= sda_sync[1];
      end
   end

   // bus events; data edges while clock stays high are start and stop
   // both lines see the same sync depth, so their order is kept; no clock
   // stretching, so the master must give four clocks per bus half period
   always_comb begin
      evt.sda      = sda_sync[1];
      evt.scl_rise = scl_sync[1] & ~scl_last;
      evt.scl_fall = ~scl_sync[1] & scl_last;
      evt.start    = scl_sync[1] & scl_last & sda_last & ~sda_sync[1];
      evt.stop     = scl_sync[1] & scl_last & ~sda_last & sda_sync[1];
   end

   assign instr = dws_decode_instr(shreg);

   // byte framing strobes: the fall after the eighth rise opens the ack
   // slot, the fall after the ninth rise closes it
   assign byte_end = evt.scl_fall && !ack_phase && (bit_cnt == ACK_SLOT);
   assign ack_end  = evt.scl_fall && ack_phase;

   // bit counter; counts the rising clock edges of the eight data bits
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bit_cnt <= BIT_CNT_RESET;
      end else if (evt.start || evt.stop) begin
         bit_cnt <= BIT_CNT_RESET;
      end else if (state == ST_IDLE || state == ST_WAIT || state == ST_INCDEC) begin
         bit_cnt <= BIT_CNT_RESET;
      end else if (evt.scl_rise && !ack_phase && bit_cnt != ACK_SLOT) begin
         bit_cnt <= bit_cnt + 4'h1;
      end else if (ack_end) begin
         bit_cnt <= BIT_CNT_RESET;
      end
   end

   // ack phase spans the ninth clock of every framed byte
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ack_phase <= 1'b0;
      end else if (evt.start || evt.stop) begin
         ack_phase <= 1'b0;
      end else if (state == ST_IDLE || state == ST_WAIT || state == ST_INCDEC) begin
         ack_phase <= 1'b0;
      end else if (byte_end) begin
         ack_phase <= 1'b1;
      end else if (ack_end) begin
         ack_phase <= 1'b0;
      end
   end

   // shift in received bits msb first on rising clock
   // address, instruction and write data share the one shift register
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         shreg <= 8'h00;
      end else if (evt.scl_rise && !ack_phase && bit_cnt != ACK_SLOT &&
                   (state == ST_ADDR || state == ST_INSTR || state == ST_WDATA)) begin
         shreg <= {shreg[6:0], evt.sda};
      end
   end

   // master acknowledge sampled on the ninth clock of a read byte
   // held for the decision at the fall that closes the ack slot
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         master_ack <= 1'b0;
      end else if (evt.scl_rise && ack_phase && state == ST_RDATA) begin
         master_ack <= ~evt.sda;
      end
   end

   // command sequencer; start restarts from anywhere, stop always ends
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
      end else if (evt.start) begin
         state <= ST_ADDR;
      end else if (evt.stop) begin
         state <= ST_IDLE;
      end else if (ack_end) begin
         // a refused read byte parks the sequencer until the next start or stop
         if (state == ST_RDATA && !master_ack) begin
            state <= ST_WAIT;
         end else begin
            state <= pend_state;
         end
      end
   end

   // next phase chosen as the ack slot opens, taken when it closes; this
   // keeps the ack decision and the phase change tied to the same byte
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pend_state <= ST_IDLE;
      end else if (byte_end) begin
         unique case (state)
            ST_ADDR: begin
               if (addr_hit(shreg, strap)) begin
                  pend_state <= ST_INSTR;
               end else begin
                  pend_state <= ST_WAIT;
               end
            end
            ST_INSTR: begin
               unique case (instr.op)
                  OPK_READ:   pend_state <= ST_RDATA;
                  OPK_WRITE:  pend_state <= ST_WDATA;
                  OPK_INCDEC: pend_state <= ST_INCDEC;
                  OPK_NONE:   pend_state <= ST_WAIT;
               endcase
            end
            ST_WDATA:  pend_state <= ST_WDATA;
            ST_RDATA:  pend_state <= ST_RDATA;
            ST_IDLE, ST_INCDEC, ST_WAIT: pend_state <= state;
         endcase
      end
   end

   // pot select latched with the instruction, held through the command
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pot_sel <= 1'b0;
      end else if (byte_end && state == ST_INSTR) begin
         pot_sel <= instr.pot_sel;
      end
   end

   // open-drain data pin: ack slots and read bits pull low, else released
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         SDA_OE_O <= 1'b0;
      end else if (evt.start || evt.stop) begin
         SDA_OE_O <= 1'b0;
      end else if (evt.scl_fall && !ack_phase && bit_cnt == ACK_SLOT) begin
         // rejected address and unknown instruction get no ack
         unique case (state)
            ST_ADDR:  SDA_OE_O <= addr_hit(shreg, strap);
            ST_INSTR: SDA_OE_O <= (instr.op != OPK_NONE);
            ST_WDATA: SDA_OE_O <= 1'b1;
            ST_RDATA: SDA_OE_O <= 1'b0;
            ST_IDLE, ST_INCDEC, ST_WAIT: SDA_OE_O <= 1'b0;
         endcase
      end else if (evt.scl_fall && ack_phase) begin
         // a read byte starts after the instruction ack or after a master ack, else the line is freed
         if (pend_state == ST_RDATA && (state != ST_RDATA || master_ack)) begin
            SDA_OE_O <= ~rd_byte[7];
         end else begin
            SDA_OE_O <= 1'b0;
         end
      end else if (evt.scl_fall && state == ST_RDATA && bit_cnt != ACK_SLOT) begin
         // after the first rise this picks bit 6, down to bit 0
         SDA_OE_O <= ~rd_byte[~bit_cnt[2:0]];
      end
   end

   // pin level when driven is always low
   // kept as a flop so that every output leaves a register
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         SDA_O <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
      end
   end

   // read byte captured on the clock rise inside the instruction ack, and again per byte
   // a fresh copy per byte, so a change between bytes is seen
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd_byte <= 8'h00;
      end else if (evt.scl_rise && ack_phase &&
                   (pend_state == ST_RDATA || state == ST_RDATA)) begin
         rd_byte <= wiper[pot_sel];
      end
   end

   // write at the fall that opens the data ack, step on each clock rise
   // the write lands before the master sees the ack, so a stop is safe
   assign wr_strobe   = evt.scl_fall && !ack_phase && bit_cnt == ACK_SLOT &&
                        state == ST_WDATA;
   assign step_strobe = evt.scl_rise && state == ST_INCDEC;
   assign step_up     = evt.sda;

   // wiper registers; updated in a couple of cycles, far inside the latency
   // bound; a stop in step mode follows one extra low-data step, as on a pin
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wiper[0] <= WIPER_RESET;
         wiper[1] <= WIPER_RESET;
      end else if (wr_strobe) begin
         wiper[pot_sel] <= shreg;
      end else if (step_strobe) begin
         wiper[pot_sel] <= dws_step(wiper[pot_sel], step_up);
      end
   end

   // position outputs straight from the registers
   // one cycle behind the wiper, far inside the update latency bound
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         WIPER_POS0_O <= WIPER_RESET;
         WIPER_POS1_O <= WIPER_RESET;
      end else begin
         WIPER_POS0_O <= wiper[0];
         WIPER_POS1_O <= wiper[1];
      end
   end

   // one-hot tap selects, one decoder per pot
   // registered, so taps move in the same cycle as the position outputs
   dws_tap_decoder #(
      .WIDTH (WIPER_W),
      .TAPS  (NUM_TAPS)
   ) u_tap0 (
      .clk_i   (CLOCK_I),
      .rst_n_i (RESETN_I),
      .pos_i   (wiper[0]),
      .tap_o   (TAP_SEL0_O)
   );

   dws_tap_decoder #(
      .WIDTH (WIPER_W),
      .TAPS  (NUM_TAPS)
   ) u_tap1 (
      .clk_i   (CLOCK_I),
      .rst_n_i (RESETN_I),
      .pos_i   (wiper[1]),
      .tap_o   (TAP_SEL1_O)
   );

endmodule : dws_dual_wiper_slave
`default_nettype wire

// ===== logic/dws_tap_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module dws_tap_decoder #(
   parameter int WIDTH = 8,
   parameter int TAPS  = 256
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] pos_i,
   output var  logic [TAPS-1:0]  tap_o
);
   import dws_pkg::*;

   // registered one-hot tap select; reset state is the midspan tap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_o <= TAPS'(1) << WIPER_RESET;
      end else begin
         tap_o <= TAPS'(1) << pos_i;
      end
   end

endmodule : dws_tap_decoder
`default_nettype wire

// ===== pkg/dws_pkg.sv
package dws_pkg;

   localparam int          CLK_PERIOD_NS      = 20;
   localparam int          WIPER_LATENCY_US   = 10;
   // longest time: rounds down
   localparam int          WIPER_LATENCY_CYC  = (WIPER_LATENCY_US * 1000) / CLK_PERIOD_NS;
   localparam int          POWERUP_DELAY_MS   = 1;
   localparam int          POWERUP_DELAY_CYC  = (POWERUP_DELAY_MS * 1000000) / CLK_PERIOD_NS;

   localparam int          WIPER_W            = 8;
   localparam int          NUM_TAPS           = 256;
   localparam logic [7:0]  WIPER_RESET        = 8'h80;
   localparam logic [7:0]  WIPER_MAX          = 8'hff;
   localparam logic [7:0]  WIPER_MIN          = 8'h00;

   // device type nibble; value is arbitrary
   localparam logic [3:0]  DEV_TYPE_DEFAULT   = 4'h6;

   // opcode and function bits, bits 7..1 of the instruction byte
   localparam logic [6:0]  OP_READ            = 7'h48;
   localparam logic [6:0]  OP_WRITE           = 7'h50;
   localparam logic [6:0]  OP_INCDEC          = 7'h10;

   localparam logic [3:0]  ACK_SLOT           = 4'h8;
   localparam logic [3:0]  BIT_CNT_RESET      = 4'h0;

   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_ADDR   = 8'h02,
      ST_INSTR  = 8'h04,
      ST_WDATA  = 8'h08,
      ST_RDATA  = 8'h10,
      ST_INCDEC = 8'h20,
      ST_WAIT   = 8'h40
   } dws_state_t;

   typedef enum logic [1:0] {
      OPK_NONE   = 2'h0,
      OPK_READ   = 2'h1,
      OPK_WRITE  = 2'h2,
      OPK_INCDEC = 2'h3
   } dws_op_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } dws_bus_evt_t;

   typedef struct packed {
      dws_op_t op;
      logic    pot_sel;
   } dws_instr_t;

   // opcode plus function bits must match exactly, else no operation
   function automatic dws_instr_t dws_decode_instr(input logic [7:0] b);
      dws_instr_t r;
      r.pot_sel = b[0];
      if (b[7:1] == OP_READ) begin
         r.op = OPK_READ;
      end else if (b[7:1] == OP_WRITE) begin
         r.op = OPK_WRITE;
      end else if (b[7:1] == OP_INCDEC) begin
         r.op = OPK_INCDEC;
      end else begin
         r.op = OPK_NONE;
      end
      return r;
   endfunction : dws_decode_instr

   // one step with saturation at both ends
   function automatic logic [7:0] dws_step(input logic [7:0] w, input logic up);
      logic [7:0] r;
      r = w;
      if (up && (w != WIPER_MAX)) begin
         r = w + 8'h01;
      end else if (!up && (w != WIPER_MIN)) begin
         r = w - 8'h01;
      end
      return r;
   endfunction : dws_step

endpackage : dws_pkg

// ===== tb/dws_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module dws_bus_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   int lag = 0; // extra low-phase cycles for a slow master
   // bus idles high on both lines
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // all moves on the falling edge of the system clock
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   // data set mid-low, sampled mid-high; clock only runs in frames
   task automatic bit_slot(input logic b, output logic s);
      sda_o = b;
      tick(2 + lag);
      scl_o = 1'b1;
      tick(2);
      s = sda_i;
      tick(2);
      scl_o = 1'b0;
      tick(2);
   endtask : bit_slot
   // park the clock low with no start, data line left alone
   task automatic clock_low();
      scl_o = 1'b0;
      tick(2);
   endtask : clock_low
   // also serves as a repeated start
   task automatic start_cond();
      sda_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
      tick(2);
   endtask : start_cond
   task automatic stop_cond();
      sda_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask : stop_cond
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask : wr_byte
   task automatic rd_byte(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, d[i]);
      end
      bit_slot(~ack, s);
   endtask : rd_byte
endmodule : dws_bus_master
`default_nettype wire

// ===== tb/dws_dual_wiper_slave_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dws_dual_wiper_slave_tb_top;
   import dws_pkg::*;
   localparam logic [7:0] ADR = {DEV_TYPE_DEFAULT, 4'ha};
   logic         clk;
   logic         rst_n = 1'b0;
   logic [3:0]   strap = 4'ha;
   logic         scl, sda_m, sda_w, sda_o, sda_oe;
   logic [7:0]   pos0, pos1;
   logic [255:0] tap0, tap1;
   int           error_cnt = 0;
   int           n_checks = 0;
   // open-drain wire with pull-up
   assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
   dws_dual_wiper_slave dut_u (
      .CLOCK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .ADDR_STRAP_I(strap), .WIPER_POS0_O(pos0),
      .WIPER_POS1_O(pos1), .TAP_SEL0_O(tap0), .TAP_SEL1_O(tap1)
   );
   dws_bus_master mst_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string what, input logic [255:0] got, input logic [255:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   task automatic pots(input logic [7:0] e0, input logic [7:0] e1);
      check("pos0", pos0, e0);
      check("pos1", pos1, e1);
      check("tap0", tap0, 256'h1 << e0);
      check("tap1", tap1, 256'h1 << e1);
   endtask : pots
   // three-byte command; acks expected per byte, msb is the address
   task automatic send3(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
                        input logic [2:0] acks);
      logic k;
      mst_u.start_cond();
      mst_u.wr_byte(a, k);
      check("addr ack", k, acks[2]);
      mst_u.wr_byte(ins, k);
      check("instr ack", k, acks[1]);
      mst_u.wr_byte(d, k);
      check("data ack", k, acks[0]);
      mst_u.stop_cond();
      mst_u.tick(10); // far inside the wiper latency bound
   endtask : send3
   // two bytes acked then refused; the value must repeat
   task automatic rd(input logic p, input logic [7:0] e);
      logic [7:0] d;
      logic       k;
      mst_u.start_cond();
      mst_u.wr_byte(ADR, k);
      mst_u.wr_byte({OP_READ, p}, k);
      check("rd ack", k, 1'b1);
      mst_u.rd_byte(d, 1'b1);
      check("rd byte 1", d, e);
      mst_u.rd_byte(d, 1'b0);
      check("rd byte 2", d, e);
      mst_u.stop_cond();
   endtask : rd
   // the stop itself brings one extra down step
   task automatic step(input logic p, input logic [2:0] dirs);
      logic k;
      mst_u.start_cond();
      mst_u.wr_byte(ADR, k);
      mst_u.wr_byte({OP_INCDEC, p}, k);
      check("step ack", k, 1'b1);
      for (int i = 0; i < 3; i++) begin
         mst_u.bit_slot(dirs[i], k);
         check("step line", k, dirs[i]);
      end
      mst_u.stop_cond();
      mst_u.tick(10);
   endtask : step
   initial begin
      logic k;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      mst_u.tick(4);
      pots(WIPER_RESET, WIPER_RESET);
      // bytes clocked with no start must be ignored
      mst_u.clock_low();
      mst_u.wr_byte(ADR, k);
      check("no start ack", k, 1'b0);
      mst_u.wr_byte({OP_WRITE, 1'b0}, k);
      mst_u.wr_byte(8'h11, k);
      mst_u.stop_cond();
      pots(WIPER_RESET, WIPER_RESET);
      send3(ADR, {OP_WRITE, 1'b0}, 8'ha5, 3'b111);
      send3(ADR, {OP_WRITE, 1'b1}, 8'h3c, 3'b111);
      pots(8'ha5, 8'h3c);
      rd(1'b1, 8'h3c);
      rd(1'b0, 8'ha5);
      // refusals: wrong type, odd function bits, unknown opcode, strap mismatch
      send3({~DEV_TYPE_DEFAULT, 4'ha}, {OP_WRITE, 1'b0}, 8'h00, 3'b000);
      send3(ADR, {OP_WRITE ^ 7'h01, 1'b0}, 8'h00, 3'b100);
      send3(ADR, 8'h00, 8'h00, 3'b100);
      strap = 4'h3;
      send3(ADR, {OP_WRITE, 1'b1}, 8'h00, 3'b000);
      strap = 4'ha;
      pots(8'ha5, 8'h3c);
      // stepping saturates at both ends
      send3(ADR, {OP_WRITE, 1'b0}, 8'hfe, 3'b111);
      send3(ADR, {OP_WRITE, 1'b1}, 8'h01, 3'b111);
      step(1'b0, 3'b111);
      step(1'b1, 3'b000);
      pots(8'hfe, 8'h00);
      // a slow master must work the same
      mst_u.lag = 5;
      send3(ADR, {OP_WRITE, 1'b1}, 8'h5a, 3'b111);
      mst_u.lag = 0;
      pots(8'hfe, 8'h5a);
      // reset in mid-run reloads midspan
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      mst_u.tick(4);
      pots(WIPER_RESET, WIPER_RESET);
      report_and_stop();
   end
   // watchdog well beyond the roughly 3600 cycles the sequence needs
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
endmodule : dws_dual_wiper_slave_tb_top
`default_nettype wire

// ===== tb/dws_props.sv
`timescale 1ns/10ps
`default_nettype none
module dws_props (
   input wire logic                         CLOCK_I,
   input wire logic                         RESETN_I,
   input wire logic                         SCL_I,
   input wire logic                         SDA_I,
   input wire logic                         SDA_O,
   input wire logic                         SDA_OE_O,
   input wire logic [3:0]                   ADDR_STRAP_I,
   input wire logic [dws_pkg::WIPER_W-1:0]  WIPER_POS0_O,
   input wire logic [dws_pkg::WIPER_W-1:0]  WIPER_POS1_O,
   input wire logic [dws_pkg::NUM_TAPS-1:0] TAP_SEL0_O,
   input wire logic [dws_pkg::NUM_TAPS-1:0] TAP_SEL1_O
);
   import dws_pkg::*;
   // one clock domain, so clock and disable are given once
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // open drain: the pin may only ever be pulled low
   a_drive_low: assert property (SDA_OE_O |-> !SDA_O)
      else $error("data pin driven high");
   a_tap_onehot: assert property ($onehot(TAP_SEL0_O) && $onehot(TAP_SEL1_O))
      else $error("tap select not one-hot");
   a_tap_pot0: assert property (TAP_SEL0_O == (256'h1 << WIPER_POS0_O))
      else $error("pot 0 tap does not follow wiper");
   a_tap_pot1: assert property (TAP_SEL1_O == (256'h1 << WIPER_POS1_O))
      else $error("pot 1 tap does not follow wiper");
   a_reset_mid: assert property ($rose(RESETN_I) |->
      WIPER_POS0_O == WIPER_RESET && WIPER_POS1_O == WIPER_RESET)
      else $error("wiper not midspan after reset");
   // data and ack only move three cycles after a bus clock fall
   a_oe_after_fall: assert property ($changed(SDA_OE_O) |->
      $past(SCL_I, 4) && !$past(SCL_I, 3))
      else $error("data drive moved away from clock fall");
   a_ack_len: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*8])
      else $error("low drive shorter than a bit slot");
   a_oe_scl_high: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
      else $error("data drive changed while clock high");
endmodule : dws_props
bind dws_dual_wiper_slave dws_props props_u (
   .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .ADDR_STRAP_I(ADDR_STRAP_I),
   .WIPER_POS0_O(WIPER_POS0_O), .WIPER_POS1_O(WIPER_POS1_O),
   .TAP_SEL0_O(TAP_SEL0_O), .TAP_SEL1_O(TAP_SEL1_O)
);
`default_nettype wire
